/* File: verilog/cia_consts.vh */
// constants for the cpu interrupt arbiter: commands, field layout, levels, register map
// assumes inclusion by the arbiter, checker and bench files, before any module
`ifndef CIA_CONSTS_VH
`define CIA_CONSTS_VH

// write-control commands
`define CIA_CMD_LOAD_PSW 6'h01
`define CIA_CMD_READ_PSW 6'h02
`define CIA_CMD_LOAD_SOFT 6'h03
`define CIA_CMD_READ_SOFT 6'h04
`define CIA_CMD_LOAD_TRAP 6'h05
`define CIA_CMD_GRANT 6'h06
`define CIA_CMD_REI 6'h07
`define CIA_CMD_CLEAR_GRANT 6'h08

// processor status, trap level and software request fields on the write bus
`define CIA_PSW_LEVEL_LSB 16
`define CIA_PSW_LEVEL_MSB 20
`define CIA_PSW_MODE_LSB 24
`define CIA_PSW_MODE_MSB 25
`define CIA_PSW_STACK_BIT 26
`define CIA_TRAP_LSB 0
`define CIA_TRAP_MSB 2
`define CIA_SOFT_LSB 0
`define CIA_SOFT_MSB 4

// priority levels of the sources
`define CIA_LEVEL_POWER_FAIL 5'h1E
`define CIA_LEVEL_TAPE 5'h17
`define CIA_LEVEL_BR7 5'h17
`define CIA_LEVEL_BR6 5'h16
`define CIA_LEVEL_BR5 5'h15
`define CIA_LEVEL_BR4 5'h14
`define CIA_LEVEL_CONSOLE 5'h14

// source index within the arbiter
`define CIA_SRC_POWER_FAIL 3'h0
`define CIA_SRC_TAPE 3'h1
`define CIA_SRC_BR7 3'h2
`define CIA_SRC_BR6 3'h3
`define CIA_SRC_BR5 3'h4
`define CIA_SRC_BR4 3'h5
`define CIA_SRC_CONSOLE 3'h6
`define CIA_SRC_SOFT 3'h7

// service vector codes
`define CIA_VEC_NONE 3'h0
`define CIA_VEC_SOFT 3'h3
`define CIA_VEC_CONSOLE 3'h4
`define CIA_VEC_BUS 3'h5
`define CIA_VEC_TAPE 3'h6
`define CIA_VEC_POWER_FAIL 3'h7

// register map, byte addresses
`define CIA_ADDR_STATUS 8'h00
`define CIA_ADDR_MASK 8'h04
`define CIA_ADDR_STATE 8'h08
`define CIA_ADDR_CONTROL 8'h0C

// status bits
`define CIA_ST_GRANT 0
`define CIA_ST_REI_FAULT 1
`define CIA_ST_POWER_FAIL 2
`define CIA_ST_VECTOR 3
`define CIA_ST_WIDTH 4

`define CIA_CONTROL_RESET 2'h3
`define CIA_RESP_OKAY 2'h0
`define CIA_RESP_SLVERR 2'h2

`endif

/* File: verilog/cia_prio_pick.v */
// picks the highest priority level among eight requesting sources
// assumes flat packed levels, five bits per source, source 0 in the low bits
`timescale 1ns/100ps
`default_nettype none

module cia_prio_pick
(
	input wire [39:0] i_levels,
	input wire [7:0] i_valid,
	output reg [2:0] o_index,
	output reg [4:0] o_level,
	output reg o_any
);

wire [4:0] level_of [0:7];
integer k;

genvar g;
generate
	for (g = 0; g < 8; g = g + 1)
	begin : unpack
		assign level_of[g] = i_levels[g*5 +: 5];
	end
endgenerate

// strict compare: on equal levels the lower index keeps the win
always @*
begin
	o_index = 3'h0;
	o_level = 5'h00;
	o_any = 1'b0;
	for (k = 0; k < 8; k = k + 1)
	begin
		if (i_valid[k] && (!o_any || level_of[k] > o_level))
		begin
			o_index = k[2:0];
			o_level = level_of[k];
			o_any = 1'b1;
		end
	end
end

endmodule

`default_nettype wire

/* File: verilog/cia_arbiter.v */
// cpu interrupt arbiter: status fields, software request, arbitration, bus grant, return check
// assumes commands from the microsequencer synchronous to i_clock and
// peripheral requests already synchronised; registers over axi4-lite
//
// Contract
// - hold priority level, stack flag, mode and trap level and return them on command.
// - store the highest software request from the write bus and arbitrate with it.
// - drive a three-bit service vector naming the highest interrupt present.
// - check a return from exception against the stored stack flag, mode and level.
// - arbitrate all hardware and software requests and encode the winner.
// - take four synchronised bus request lines and grant the highest one.
// - request lines 7, 6, 5 and 4 carry levels 17, 16, 15 and 14.
// - the bus request lines are interrupt inputs in the arbitration.
// - on command grant the previously seen request, line 7 on its own line.
// - never drive more than one grant line at a time.
// - console interrupts sit at level 14.
// - tape interface interrupts sit at level 17.
// - grant a bus request only when its level exceeds the current level.
// - a power-fail request raises a power-fail interrupt.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "cia_consts.vh"

module cia_arbiter
(
	input wire i_clock,
	input wire i_reset_n,
	input wire i_command_valid,
	input wire [5:0] i_write_control_field,
	input wire [31:0] i_write_bus,
	output reg [31:0] o_write_bus,
	output reg o_write_bus_oe,
	input wire [7:4] i_sync_bus_request,
	output reg o_top_grant_line,
	output reg [6:4] o_top_grant_lines,
	input wire i_power_fail_request,
	input wire i_console_request,
	input wire i_tape_request,
	output reg [2:0] o_service_vector_bits,
	output reg o_interrupt_present,
	output reg o_rei_fault,
	output reg o_irq,
	input wire [7:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output reg o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output reg o_s_axi_wready,
	output reg [1:0] o_s_axi_bresp,
	output reg o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [7:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output reg o_s_axi_arready,
	output reg [31:0] o_s_axi_rdata,
	output reg [1:0] o_s_axi_rresp,
	output reg o_s_axi_rvalid,
	input wire i_s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// status fields and state

reg [4:0] priority_level;
reg interrupt_stack_flag;
reg [1:0] current_mode_field;
reg [2:0] async_trap_level;
reg [4:0] highest_soft_request;
reg grant_active;
reg [2:0] grant_index;
reg power_fail_seen;
reg [`CIA_ST_WIDTH-1:0] status;
reg [`CIA_ST_WIDTH-1:0] mask;
reg [1:0] control;
reg [2:0] last_vector;

wire [2:0] win_index;
wire [4:0] win_level;
wire win_any;

function [2:0] vector_of;
	input [2:0] index;
	begin
		if (index == `CIA_SRC_POWER_FAIL)
			vector_of = `CIA_VEC_POWER_FAIL;
		else if (index == `CIA_SRC_TAPE)
			vector_of = `CIA_VEC_TAPE;
		else if (index == `CIA_SRC_CONSOLE)
			vector_of = `CIA_VEC_CONSOLE;
		else if (index == `CIA_SRC_SOFT)
			vector_of = `CIA_VEC_SOFT;
		else
			vector_of = `CIA_VEC_BUS;
	end
endfunction

function is_bus_source;
	input [2:0] index;
	begin
		is_bus_source = (index >= `CIA_SRC_BR7) && (index <= `CIA_SRC_BR4);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// arbitration

wire [39:0] levels = {highest_soft_request, `CIA_LEVEL_CONSOLE, `CIA_LEVEL_BR4,
	`CIA_LEVEL_BR5, `CIA_LEVEL_BR6, `CIA_LEVEL_BR7,
	`CIA_LEVEL_TAPE, `CIA_LEVEL_POWER_FAIL};
wire [7:0] valid = {highest_soft_request != 5'h00, i_console_request,
	i_sync_bus_request[4], i_sync_bus_request[5], i_sync_bus_request[6],
	i_sync_bus_request[7], i_tape_request, i_power_fail_request};

cia_prio_pick u_pick
(
	.i_levels(levels),
	.i_valid(valid),
	.o_index(win_index),
	.o_level(win_level),
	.o_any(win_any)
);

// a request at or below the current level is held off, not lost
wire present = win_any && (win_level > priority_level);
wire [2:0] next_vector = present ? vector_of(win_index) : `CIA_VEC_NONE;

////////////////////////////////////////////////////////////////////////////////
// return from exception check

wire [4:0] new_level = i_write_bus[`CIA_PSW_LEVEL_MSB:`CIA_PSW_LEVEL_LSB];
wire [1:0] new_mode = i_write_bus[`CIA_PSW_MODE_MSB:`CIA_PSW_MODE_LSB];
wire new_stack = i_write_bus[`CIA_PSW_STACK_BIT];
// no return to a more privileged mode, to a higher level or onto the interrupt stack from off it
wire rei_bad = (new_mode < current_mode_field) || (new_level > priority_level)
	|| (new_stack && !interrupt_stack_flag) || (new_stack && new_mode != 2'h0)
	|| (new_mode != 2'h0 && new_level != 5'h00);

wire command = i_command_valid;
wire [5:0] cmd = i_write_control_field;

////////////////////////////////////////////////////////////////////////////////
// microcode side

always @(posedge i_clock)
begin
	if (!i_reset_n)
	begin
		priority_level <= 5'h1F;
		interrupt_stack_flag <= 1'b1;
		current_mode_field <= 2'h0;
		async_trap_level <= 3'h4;
		highest_soft_request <= 5'h00;
		grant_active <= 1'b0;
		grant_index <= 3'h0;
		o_write_bus <= 32'h00000000;
		o_write_bus_oe <= 1'b0;
		o_rei_fault <= 1'b0;
	end
	else
	begin
		o_write_bus_oe <= 1'b0;
		o_rei_fault <= 1'b0;
		if (grant_active && !valid[grant_index])
			grant_active <= 1'b0;
		if (command)
		begin
			case (cmd)
			`CIA_CMD_LOAD_PSW:
			begin
				priority_level <= new_level;
				current_mode_field <= new_mode;
				interrupt_stack_flag <= new_stack;
			end
			`CIA_CMD_READ_PSW:
			begin
				o_write_bus <= 32'h00000000;
				o_write_bus[`CIA_PSW_LEVEL_MSB:`CIA_PSW_LEVEL_LSB] <= priority_level;
				o_write_bus[`CIA_PSW_MODE_MSB:`CIA_PSW_MODE_LSB] <= current_mode_field;
				o_write_bus[`CIA_PSW_STACK_BIT] <= interrupt_stack_flag;
				o_write_bus[`CIA_TRAP_MSB:`CIA_TRAP_LSB] <= async_trap_level;
				o_write_bus_oe <= 1'b1;
			end
			`CIA_CMD_LOAD_SOFT:
				highest_soft_request <= i_write_bus[`CIA_SOFT_MSB:`CIA_SOFT_LSB];
			`CIA_CMD_READ_SOFT:
			begin
				o_write_bus <= {27'h0000000, highest_soft_request};
				o_write_bus_oe <= 1'b1;
			end
			`CIA_CMD_LOAD_TRAP:
				async_trap_level <= i_write_bus[`CIA_TRAP_MSB:`CIA_TRAP_LSB];
			`CIA_CMD_GRANT:
			begin
				// one index drives all grant lines, so at most one can be high
				if (control[0] && win_any && is_bus_source(win_index)
					&& win_level > priority_level)
				begin
					grant_active <= 1'b1;
					grant_index <= win_index;
				end
			end
			`CIA_CMD_REI:
			begin
				if (rei_bad)
					o_rei_fault <= 1'b1;
				else
				begin
					priority_level <= new_level;
					current_mode_field <= new_mode;
					interrupt_stack_flag <= new_stack;
				end
			end
			`CIA_CMD_CLEAR_GRANT:
				grant_active <= 1'b0;
			default:
				o_write_bus_oe <= 1'b0;
			endcase
		end
	end
end

// grant and vector outputs straight from flops
always @(posedge i_clock)
begin
	if (!i_reset_n)
	begin
		o_top_grant_line <= 1'b0;
		o_top_grant_lines <= 3'h0;
		o_service_vector_bits <= `CIA_VEC_NONE;
		o_interrupt_present <= 1'b0;
		last_vector <= `CIA_VEC_NONE;
	end
	else
	begin
		o_top_grant_line <= grant_active && grant_index == `CIA_SRC_BR7;
		o_top_grant_lines[6] <= grant_active && grant_index == `CIA_SRC_BR6;
		o_top_grant_lines[5] <= grant_active && grant_index == `CIA_SRC_BR5;
		o_top_grant_lines[4] <= grant_active && grant_index == `CIA_SRC_BR4;
		o_service_vector_bits <= next_vector & {3{control[1]}};
		o_interrupt_present <= present && control[1];
		last_vector <= next_vector;
	end
end

////////////////////////////////////////////////////////////////////////////////
// events and interrupt

reg prev_power_fail;
wire [`CIA_ST_WIDTH-1:0] events;
assign events[`CIA_ST_GRANT] = command && cmd == `CIA_CMD_GRANT && control[0] && win_any
	&& is_bus_source(win_index) && win_level > priority_level;
assign events[`CIA_ST_REI_FAULT] = command && cmd == `CIA_CMD_REI && rei_bad;
assign events[`CIA_ST_POWER_FAIL] = i_power_fail_request && !prev_power_fail;
assign events[`CIA_ST_VECTOR] = next_vector != `CIA_VEC_NONE && last_vector == `CIA_VEC_NONE;

wire aw_take = o_s_axi_awready && i_s_axi_awvalid;
wire w_take = o_s_axi_wready && i_s_axi_wvalid;
reg aw_have;
reg w_have;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire do_write = aw_have && w_have && !o_s_axi_bvalid;
wire write_status = do_write && aw_addr == `CIA_ADDR_STATUS && w_strb[0];
wire [`CIA_ST_WIDTH-1:0] clear_bits = write_status ? w_data[`CIA_ST_WIDTH-1:0] : 4'h0;

always @(posedge i_clock)
begin
	if (!i_reset_n)
	begin
		status <= 4'h0;
		prev_power_fail <= 1'b0;
		power_fail_seen <= 1'b0;
		o_irq <= 1'b0;
	end
	else
	begin
		prev_power_fail <= i_power_fail_request;
		// set wins over a clear in the same cycle
		status <= (status & ~clear_bits) | events;
		if (events[`CIA_ST_POWER_FAIL])
			power_fail_seen <= 1'b1;
		o_irq <= |(((status & ~clear_bits) | events) & mask);
	end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

always @(posedge i_clock)
begin
	if (!i_reset_n)
	begin
		aw_have <= 1'b0;
		w_have <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		o_s_axi_awready <= 1'b1;
		o_s_axi_wready <= 1'b1;
		o_s_axi_bvalid <= 1'b0;
		o_s_axi_bresp <= `CIA_RESP_OKAY;
		mask <= 4'h0;
		control <= `CIA_CONTROL_RESET;
	end
	else
	begin
		if (aw_take)
		begin
			aw_have <= 1'b1;
			aw_addr <= i_s_axi_awaddr;
			o_s_axi_awready <= 1'b0;
		end
		if (w_take)
		begin
			w_have <= 1'b1;
			w_data <= i_s_axi_wdata;
			w_strb <= i_s_axi_wstrb;
			o_s_axi_wready <= 1'b0;
		end
		if (do_write)
		begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp <= `CIA_RESP_OKAY;
			if (aw_addr == `CIA_ADDR_STATUS)
				o_s_axi_bresp <= `CIA_RESP_OKAY;
			else if (aw_addr == `CIA_ADDR_MASK)
			begin
				if (w_strb[0])
					mask <= w_data[`CIA_ST_WIDTH-1:0];
			end
			else if (aw_addr == `CIA_ADDR_CONTROL)
			begin
				if (w_strb[0])
					control <= w_data[1:0];
			end
			else if (aw_addr != `CIA_ADDR_STATE)
				o_s_axi_bresp <= `CIA_RESP_SLVERR;
		end
		if (o_s_axi_bvalid && i_s_axi_bready)
		begin
			o_s_axi_bvalid <= 1'b0;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready <= 1'b1;
		end
	end
end

always @(posedge i_clock)
begin
	if (!i_reset_n)
	begin
		o_s_axi_arready <= 1'b1;
		o_s_axi_rvalid <= 1'b0;
		o_s_axi_rdata <= 32'h00000000;
		o_s_axi_rresp <= `CIA_RESP_OKAY;
	end
	else
	begin
		if (o_s_axi_arready && i_s_axi_arvalid)
		begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp <= `CIA_RESP_OKAY;
			o_s_axi_rdata <= 32'h00000000;
			if (i_s_axi_araddr == `CIA_ADDR_STATUS)
				o_s_axi_rdata <= {28'h0000000, status};
			else if (i_s_axi_araddr == `CIA_ADDR_MASK)
				o_s_axi_rdata <= {28'h0000000, mask};
			else if (i_s_axi_araddr == `CIA_ADDR_STATE)
				o_s_axi_rdata <= {power_fail_seen, grant_active, grant_index,
					interrupt_stack_flag, current_mode_field, 3'h0, priority_level,
					3'h0, highest_soft_request, last_vector, 2'h0, async_trap_level};
			else if (i_s_axi_araddr == `CIA_ADDR_CONTROL)
				o_s_axi_rdata <= {30'h00000000, control};
			else
				o_s_axi_rresp <= `CIA_RESP_SLVERR;
		end
		if (o_s_axi_rvalid && i_s_axi_rready)
		begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_arready <= 1'b1;
		end
	end
end

endmodule

`default_nettype wire

/* File: testbench/cia_arbiter_sva.sv */
// checker for the cpu interrupt arbiter: vector, grant and command timing
// assumes the arbiter's single clock and its synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "cia_consts.vh"
////////////////////////////////
module cia_arbiter_chk
(
	input wire i_clock,
	input wire i_reset_n,
	input wire i_command_valid,
	input wire [5:0] i_write_control_field,
	input wire [7:4] i_sync_bus_request,
	input wire i_power_fail_request,
	input wire i_console_request,
	input wire i_tape_request,
	input wire o_top_grant_line,
	input wire [6:4] o_top_grant_lines,
	input wire [2:0] o_service_vector_bits,
	input wire o_interrupt_present,
	input wire o_rei_fault,
	input wire o_write_bus_oe
);
	wire [2:0] vec = o_service_vector_bits;
	wire [3:0] grants = {o_top_grant_line, o_top_grant_lines};
	wire rd_cmd = i_command_valid && (i_write_control_field == `CIA_CMD_READ_PSW);
	wire gr_cmd = i_command_valid && (i_write_control_field == `CIA_CMD_GRANT);
	wire rei_cmd = i_command_valid && (i_write_control_field == `CIA_CMD_REI);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	chk_grant_single: assert property (
		$onehot0(grants)) else $error("more than one grant line");
	chk_read_answer: assert property (
		rd_cmd |=> o_write_bus_oe) else $error("no readback after read");
	chk_grant_cause: assert property (
		$rose(|grants) |-> $past(gr_cmd, 2)) else $error("grant without command");
	chk_grant_bus_win: assert property (
		$rose(|grants) |-> $past(vec, 2) == `CIA_VEC_BUS) else $error("grant to non-bus");
	chk_pf_vector: assert property (
		vec == `CIA_VEC_POWER_FAIL |-> $past(i_power_fail_request)) else $error("bad pf vector");
	chk_pf_wins: assert property (
		$past(i_power_fail_request) && vec != `CIA_VEC_NONE
		|-> vec inside {`CIA_VEC_POWER_FAIL, `CIA_VEC_SOFT}) else $error("pf lost");
	chk_tape_vector: assert property (
		vec == `CIA_VEC_TAPE |-> $past(i_tape_request) && !$past(i_power_fail_request))
		else $error("bad tape vector");
	chk_console_vector: assert property (
		vec == `CIA_VEC_CONSOLE |-> $past(i_console_request) && !$past(i_tape_request)
		&& $past(i_sync_bus_request) == 4'h0) else $error("bad console vector");
	chk_bus_vector: assert property (
		vec == `CIA_VEC_BUS |-> $past(|i_sync_bus_request)) else $error("bad bus vector");
	chk_rei_pulse: assert property (
		$rose(o_rei_fault) |-> $past(rei_cmd)) else $error("fault without check");
	chk_present_vec: assert property (
		o_interrupt_present |-> vec != `CIA_VEC_NONE) else $error("present with no vector");
	cover property (o_rei_fault);
	cover property ($rose(o_top_grant_line));
	cover property (vec == `CIA_VEC_SOFT);
endmodule
bind cia_arbiter cia_arbiter_chk u_chk (.*);
`default_nettype wire

/* File: testbench/cia_bus_device.sv */
// model of the peripheral devices that request the bus on four lines
// assumes grants from the arbiter and one want level per line from the bench
`timescale 1ns/100ps
`default_nettype none
module cia_bus_device
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [7:4] i_want,
	input wire logic i_hold,
	input wire logic i_grant7,
	input wire logic [6:4] i_grant_low,
	output logic [7:4] o_request
);
	logic [7:4] served;
	logic [7:4] taken;
	// a holding device is a slow one: it keeps its request up though granted
	assign taken = {i_grant7, i_grant_low} & {4{~i_hold}};
	always @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			served <= 4'h0;
			o_request <= 4'h0;
		end
		else
		begin
			served <= i_want & (served | taken);
			o_request <= i_want & ~served & ~taken;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/cia_arbiter_bench.sv */
// self-checking bench for the cpu interrupt arbiter
// assumes the arbiter, its bound checker and the bus device model
`timescale 1ns/100ps
`default_nettype none
`include "cia_consts.vh"
////////////////////////////////
module cia_arbiter_bench;
	logic i_clock = 1'h0, i_reset_n = 1'h0, i_command_valid = 1'h0, i_hold = 1'h0;
	logic i_power_fail_request = 1'h0, i_console_request = 1'h0, i_tape_request = 1'h0;
	logic [7:4] i_want = 4'h0, i_sync_bus_request;
	logic [5:0] i_write_control_field = 6'h00;
	logic [31:0] i_write_bus = 32'h0, i_s_axi_wdata = 32'h0, o_write_bus, o_s_axi_rdata;
	logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
	logic [3:0] i_s_axi_wstrb = 4'hF;
	logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
	logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
	logic [6:4] o_top_grant_lines;
	logic [2:0] o_service_vector_bits;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic o_write_bus_oe, o_top_grant_line, o_interrupt_present, o_rei_fault, o_irq;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	int fail_count = 0;
	int checks_done = 0;
	cia_arbiter u_dut (.*);
	cia_bus_device u_dev (.*, .i_grant7(o_top_grant_line), .i_grant_low(o_top_grant_lines),
		.o_request(i_sync_bus_request));
	always #50 i_clock = ~i_clock;
	////////////////////////////////
	task print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] psw(input logic [4:0] l, input logic [1:0] m,
		input logic s, input logic [2:0] t);
		psw = {5'h00, s, m, 3'h0, l, 13'h0000, t};
	endfunction
	task cmd(input logic [5:0] c, input logic [31:0] d);
		@(posedge i_clock);
		i_command_valid <= 1'h1;
		i_write_control_field <= c;
		i_write_bus <= d;
		@(posedge i_clock);
		i_command_valid <= 1'h0;
	endtask
	task rd(input logic [5:0] c, input logic [31:0] e);
		cmd(c, 32'h0);
		#1;
		chk(o_write_bus_oe, 1'h1);
		chk(o_write_bus, e);
	endtask
	// grant pins follow the command by two edges
	task gr(input logic [5:0] c, input logic [3:0] e);
		cmd(c, 32'h0);
		repeat (2) @(posedge i_clock);
		#1;
		chk({o_top_grant_line, o_top_grant_lines}, e);
	endtask
	// each valid drops at the edge where its own ready was seen high
	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_open;
		logic w_open;
		@(posedge i_clock);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		i_s_axi_bready <= 1'h1;
		aw_open = 1'h1;
		w_open = 1'h1;
		do
		begin
			@(posedge i_clock);
			if (aw_open && o_s_axi_awready)
			begin
				aw_open = 1'h0;
				i_s_axi_awvalid <= 1'h0;
			end
			if (w_open && o_s_axi_wready)
			begin
				w_open = 1'h0;
				i_s_axi_wvalid <= 1'h0;
			end
		end
		while (aw_open || w_open || !o_s_axi_bvalid);
		i_s_axi_bready <= 1'h0;
		chk(o_s_axi_bresp, r);
	endtask
	task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge i_clock);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'h1;
		i_s_axi_rready <= 1'h1;
		do @(posedge i_clock); while (!o_s_axi_arready);
		i_s_axi_arvalid <= 1'h0;
		do @(posedge i_clock); while (!o_s_axi_rvalid);
		i_s_axi_rready <= 1'h0;
		chk(o_s_axi_rdata, e);
		chk(o_s_axi_rresp, r);
	endtask
	// current level is 10 while the vector table runs, so every bus line can win
	task vec(input logic [3:0] b, input t, c, p, input logic [4:0] s, input logic [2:0] e,
		input logic [4:0] lv);
		cmd(`CIA_CMD_LOAD_SOFT, {27'h0, s});
		i_want <= b;
		i_tape_request <= t;
		i_console_request <= c;
		i_power_fail_request <= p;
		repeat (3) @(posedge i_clock);
		#1;
		chk(o_service_vector_bits, e);
		chk(o_interrupt_present, lv > 5'h10);
	endtask
	////////////////////////////////
	task t_fields();
		rd(`CIA_CMD_READ_PSW, psw(5'h1F, 2'h0, 1'h1, 3'h4));
		cmd(`CIA_CMD_LOAD_PSW, psw(5'h15, 2'h1, 1'h0, 3'h0));
		cmd(`CIA_CMD_LOAD_TRAP, 32'h3);
		rd(`CIA_CMD_READ_PSW, psw(5'h15, 2'h1, 1'h0, 3'h3));
		cmd(`CIA_CMD_LOAD_SOFT, 32'h12);
		rd(`CIA_CMD_READ_SOFT, 32'h12);
		axr(`CIA_ADDR_CONTROL, 32'h3, `CIA_RESP_OKAY);
		axr(`CIA_ADDR_MASK, 32'h0, `CIA_RESP_OKAY);
		axr(8'h10, 32'h0, `CIA_RESP_SLVERR);
		axw(8'h10, 32'h1, `CIA_RESP_SLVERR);
	endtask
	task t_vectors();
		logic [4:0] lv;
		cmd(`CIA_CMD_LOAD_PSW, psw(5'h10, 2'h0, 1'h0, 3'h0));
		for (int i = 4; i < 8; i++)
		begin
			lv = 5'h10 + i[4:0];
			vec(4'h1 << (i - 4), 0, 0, 0, lv - 5'h1, `CIA_VEC_BUS, lv);
			vec(4'h1 << (i - 4), 0, 0, 0, lv + 5'h1, `CIA_VEC_SOFT, lv + 5'h1);
		end
		vec(4'h0, 0, 1, 0, 5'h13, `CIA_VEC_CONSOLE, 5'h14);
		vec(4'h0, 0, 1, 0, 5'h15, `CIA_VEC_SOFT, 5'h15);
		vec(4'h0, 1, 0, 0, 5'h16, `CIA_VEC_TAPE, 5'h17);
		vec(4'h0, 1, 0, 0, 5'h18, `CIA_VEC_SOFT, 5'h18);
		vec(4'h8, 0, 1, 0, 5'h00, `CIA_VEC_BUS, 5'h17);
		vec(4'hF, 1, 1, 1, 5'h1D, `CIA_VEC_POWER_FAIL, 5'h1E);
		vec(4'h0, 0, 0, 0, 5'h00, `CIA_VEC_NONE, 5'h00);
		// the grant scenarios rely on level 15 again
		cmd(`CIA_CMD_LOAD_PSW, psw(5'h15, 2'h1, 1'h0, 3'h0));
	endtask
	task t_grants();
		@(posedge i_clock);
		i_want <= 4'h4;
		repeat (3) @(posedge i_clock);
		gr(`CIA_CMD_GRANT, 4'h4);
		repeat (4) @(posedge i_clock);
		chk({o_top_grant_line, o_top_grant_lines}, 4'h0);
		i_want <= 4'h2;
		i_hold <= 1'h1;
		repeat (3) @(posedge i_clock);
		gr(`CIA_CMD_GRANT, 4'h0);
		@(posedge i_clock);
		i_want <= 4'hA;
		repeat (3) @(posedge i_clock);
		gr(`CIA_CMD_GRANT, 4'h8);
		gr(`CIA_CMD_CLEAR_GRANT, 4'h0);
		@(posedge i_clock);
		i_hold <= 1'h0;
		gr(`CIA_CMD_GRANT, 4'h8);
		cmd(`CIA_CMD_LOAD_PSW, psw(5'h00, 2'h0, 1'h0, 3'h0));
		repeat (2) @(posedge i_clock);
		gr(`CIA_CMD_GRANT, 4'h2);
		@(posedge i_clock);
		i_want <= 4'h0;
	endtask
	task t_rei();
		cmd(`CIA_CMD_LOAD_PSW, psw(5'h05, 2'h0, 1'h0, 3'h0));
		cmd(`CIA_CMD_REI, psw(5'h07, 2'h0, 1'h0, 3'h0));
		#1 chk(o_rei_fault, 1'h1);
		rd(`CIA_CMD_READ_PSW, psw(5'h05, 2'h0, 1'h0, 3'h3));
		cmd(`CIA_CMD_REI, psw(5'h03, 2'h1, 1'h0, 3'h0));
		#1 chk(o_rei_fault, 1'h1);
		cmd(`CIA_CMD_REI, psw(5'h00, 2'h0, 1'h1, 3'h0));
		#1 chk(o_rei_fault, 1'h1);
		cmd(`CIA_CMD_REI, psw(5'h00, 2'h1, 1'h0, 3'h0));
		#1 chk(o_rei_fault, 1'h0);
	endtask
	task t_irq();
		axw(`CIA_ADDR_MASK, 32'h4, `CIA_RESP_OKAY);
		axw(`CIA_ADDR_STATUS, 32'hF, `CIA_RESP_OKAY);
		@(posedge i_clock);
		i_power_fail_request <= 1'h1;
		repeat (3) @(posedge i_clock);
		#1 chk(o_irq, 1'h1);
		axr(`CIA_ADDR_STATUS, 32'hC, `CIA_RESP_OKAY);
		axw(`CIA_ADDR_MASK, 32'h0, `CIA_RESP_OKAY);
		repeat (2) @(posedge i_clock);
		#1 chk(o_irq, 1'h0);
		axw(`CIA_ADDR_STATUS, 32'h4, `CIA_RESP_OKAY);
		axr(`CIA_ADDR_STATUS, 32'h8, `CIA_RESP_OKAY);
		i_power_fail_request <= 1'h0;
	endtask
	initial
	begin
		repeat (20) @(posedge i_clock);
		i_reset_n <= 1'h1;
		t_fields();
		t_vectors();
		t_grants();
		t_rei();
		t_irq();
		print_verdict();
	end
	// the run takes well under a thousand cycles; this catches a stalled handshake
	initial
	begin
		repeat (5000) @(posedge i_clock);
		fail_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
